// >>> logic/dbg_cfg.svh
// Register indexes, reset values and field constants of the dual byte port block.
`ifndef DBG_CFG_SVH
`define DBG_CFG_SVH
`define DBG_PORT_WIDTH 8
`define DBG_OFS_A_PULLUP 16'hff9f
`define DBG_OFS_A_DATA 16'hffd9
`define DBG_OFS_B_DATA 16'hffda
`define DBG_OFS_A_DIR 16'hffe9
`define DBG_OFS_B_DIR 16'hffea
`define DBG_OFS_MODE 16'hfff0
`define DBG_RST_A_PULLUP 8'h00
`define DBG_RST_A_DATA 8'h00
`define DBG_RST_B_DATA 8'h00
`define DBG_RST_A_DIR 8'h00
`define DBG_RST_B_DIR 8'h00
`define DBG_WO_READ 8'hff
`define DBG_MODE_WIDTH 2
`endif

// >>> logic/dbg_gpio_ports.sv
// Dual byte general purpose port block with APB register access.
//
// Contract
// RL1 - Each port has an eight bit output latch, bit n drives pin n.
// RL2 - Port A data read returns latch bit where direction is one.
// RL3 - Port A data read returns pin level where direction is zero.
// RL4 - Port A direction one drives latch out; zero turns driver off.
// RL5 - Port A direction register is write only and reads all ones.
// RL6 - Port A pull-up follows its enable bit only while pin is input.
// RL7 - Port A pull-up enable register is read/write and resets to zero.
// RL8 - Port A data latch resets to zero.
// RL9 - Port A direction resets to zero, all pins inputs.
// RL10 - In standby port A pins float unless pull-up on, then high.
// RL11 - Port B data read returns latch for outputs, pin level for inputs.
// RL12 - Port B direction one is output, zero input; no pull-up.
// RL13 - Port B direction register is write only and reads all ones.
// RL14 - Port B data latch resets to zero.
// RL15 - Port B direction resets to zero, all pins inputs.
// RL16 - Pins float in reset, hold in sleep, work in active mode.
`timescale 1ns/1ps
`include "dbg_cfg.svh"
module dbg_gpio_ports (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] portAPinIn,
   output logic [7:0] portAPinOut,
   output logic [7:0] portAPinOe,
   output logic [7:0] portAPullupOn,
   input wire logic [7:0] portBPinIn,
   output logic [7:0] portBPinOut,
   output logic [7:0] portBPinOe
);

   ////////////////////////////////////////////////////////////////////////////////
   dbg_pkg::dbg_state_t stReg;
   dbg_pkg::dbg_state_t stNext;
   logic wrEn;
   logic rdEn;
   logic [15:0] addr;
   logic [7:0] aPuWant;

   // Each register owns one aligned word, so the bus address is four times its index.
   assign addr = (paddr[1:0] == 2'b00) ? paddr[17:2] : 16'h0000;
   assign wrEn = psel && penable && pwrite && pstrb[0];
   assign rdEn = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = stReg.rdataReg;
   assign portAPinOut = stReg.aOutReg;
   assign portAPinOe = stReg.aOeReg;
   assign portAPullupOn = stReg.aPuReg;
   assign portBPinOut = stReg.bOutReg;
   assign portBPinOe = stReg.bOeReg;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      stNext = stReg;
      if (wrEn) begin
         if (addr == `DBG_OFS_A_PULLUP) begin
            stNext.aPullupReg = pwdata[7:0]; // RL7
         end else if (addr == `DBG_OFS_A_DATA) begin
            stNext.aDataReg = pwdata[7:0]; // RL1
         end else if (addr == `DBG_OFS_B_DATA) begin
            stNext.bDataReg = pwdata[7:0]; // RL1
         end else if (addr == `DBG_OFS_A_DIR) begin
            stNext.aDirReg = pwdata[7:0];
         end else if (addr == `DBG_OFS_B_DIR) begin
            stNext.bDirReg = pwdata[7:0];
         end else if (addr == `DBG_OFS_MODE) begin
            stNext.modeReg = dbg_pkg::dbg_mode_t'(pwdata[`DBG_MODE_WIDTH-1:0]);
         end
      end
      if (rdEn) begin
         stNext.rdataReg = 32'h00000000;
         if (addr == `DBG_OFS_A_PULLUP) begin
            stNext.rdataReg[7:0] = stReg.aPullupReg;
         end else if (addr == `DBG_OFS_A_DATA) begin
            stNext.rdataReg[7:0] = (stReg.aDirReg & stReg.aDataReg) |
               (~stReg.aDirReg & portAPinIn); // RL2 RL3
         end else if (addr == `DBG_OFS_B_DATA) begin
            stNext.rdataReg[7:0] = (stReg.bDirReg & stReg.bDataReg) |
               (~stReg.bDirReg & portBPinIn); // RL11
         end else if (addr == `DBG_OFS_A_DIR) begin
            stNext.rdataReg[7:0] = `DBG_WO_READ; // RL5
         end else if (addr == `DBG_OFS_B_DIR) begin
            stNext.rdataReg[7:0] = `DBG_WO_READ; // RL13
         end else if (addr == `DBG_OFS_MODE) begin
            stNext.rdataReg[`DBG_MODE_WIDTH-1:0] = stReg.modeReg;
         end
      end
      aPuWant = stNext.aPullupReg & ~stNext.aDirReg; // RL6
      case (stNext.modeReg)
         dbg_pkg::DBG_SLEEP: begin
            stNext.aOutReg = stReg.aOutReg; // RL16
         end
         dbg_pkg::DBG_STANDBY: begin
            stNext.aOutReg = 8'h00; // RL10
            stNext.aOeReg = 8'h00;
            stNext.aPuReg = aPuWant;
            stNext.bOutReg = 8'h00;
            stNext.bOeReg = 8'h00;
         end
         default: begin
            stNext.aOutReg = stNext.aDataReg; // RL4
            stNext.aOeReg = stNext.aDirReg; // RL4
            stNext.aPuReg = aPuWant; // RL6
            stNext.bOutReg = stNext.bDataReg; // RL12
            stNext.bOeReg = stNext.bDirReg; // RL12
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         stReg.aPullupReg <= `DBG_RST_A_PULLUP; // RL7
         stReg.aDataReg <= `DBG_RST_A_DATA; // RL8
         stReg.bDataReg <= `DBG_RST_B_DATA; // RL14
         stReg.aDirReg <= `DBG_RST_A_DIR; // RL9
         stReg.bDirReg <= `DBG_RST_B_DIR; // RL15
         stReg.aOutReg <= 8'h00;
         stReg.aOeReg <= 8'h00; // RL16
         stReg.aPuReg <= 8'h00;
         stReg.bOutReg <= 8'h00;
         stReg.bOeReg <= 8'h00; // RL16
         stReg.rdataReg <= 32'h00000000;
         stReg.modeReg <= dbg_pkg::DBG_ACTIVE;
      end else begin
         stReg <= stNext;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   chk_a_dir_ones: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL5
      (rdEn && addr == `DBG_OFS_A_DIR) |=> prdata == 32'h000000ff)
      else $error("Port A direction read not all ones.");
   chk_b_dir_ones: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL13
      (rdEn && addr == `DBG_OFS_B_DIR) |=> prdata == 32'h000000ff)
      else $error("Port B direction read not all ones.");
   chk_a_read_mux: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL2
      (rdEn && addr == `DBG_OFS_A_DATA) |=> prdata[7:0] ==
      (($past(stReg.aDirReg) & $past(stReg.aDataReg)) |
      (~$past(stReg.aDirReg) & $past(portAPinIn))))
      else $error("Port A data read mux wrong.");
   chk_b_read_mux: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL11
      (rdEn && addr == `DBG_OFS_B_DATA) |=> prdata[7:0] ==
      (($past(stReg.bDirReg) & $past(stReg.bDataReg)) |
      (~$past(stReg.bDirReg) & $past(portBPinIn))))
      else $error("Port B data read mux wrong.");
   chk_pullup_input: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL6
      (portAPullupOn & stReg.aDirReg) == 8'h00)
      else $error("Pull-up on an output pin.");
   chk_a_drive: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL4
      (stReg.modeReg == dbg_pkg::DBG_ACTIVE && $past(stReg.modeReg) == dbg_pkg::DBG_ACTIVE)
      |-> portAPinOe == stReg.aDirReg && portAPinOut == stReg.aDataReg)
      else $error("Port A drive does not follow latch.");
   sequence seqStandbyHeld;
      stReg.modeReg == dbg_pkg::DBG_STANDBY ##1 stReg.modeReg == dbg_pkg::DBG_STANDBY;
   endsequence
   sequence seqSleepHeld;
      stReg.modeReg == dbg_pkg::DBG_SLEEP && stNext.modeReg == dbg_pkg::DBG_SLEEP;
   endsequence
   chk_standby_float: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
      seqStandbyHeld |-> portAPinOe == 8'h00 && portBPinOe == 8'h00)
      else $error("Pins driven in standby.");
   chk_standby_pullup: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL10
      stReg.modeReg == dbg_pkg::DBG_STANDBY
      |-> portAPullupOn == (stReg.aPullupReg & ~stReg.aDirReg))
      else $error("Standby pull-up does not follow enable.");
   chk_sleep_oe_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL16
      seqSleepHeld |=> $stable(portAPinOe) && $stable(portBPinOe))
      else $error("Pin enables changed in sleep.");
   chk_b_drive: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL12
      (stReg.modeReg == dbg_pkg::DBG_ACTIVE && $past(stReg.modeReg) == dbg_pkg::DBG_ACTIVE)
      |-> portBPinOe == stReg.bDirReg && portBPinOut == stReg.bDataReg)
      else $error("Port B drive does not follow latch.");
   chk_a_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL1
      (wrEn && addr == `DBG_OFS_A_DATA) |=> stReg.aDataReg == $past(pwdata[7:0]))
      else $error("Port A data write lost.");
   chk_b_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL1
      (wrEn && addr == `DBG_OFS_B_DATA) |=> stReg.bDataReg == $past(pwdata[7:0]))
      else $error("Port B data write lost.");
   chk_a_dir_lands: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL4
      (wrEn && addr == `DBG_OFS_A_DIR) |=> stReg.aDirReg == $past(pwdata[7:0]))
      else $error("Port A direction write lost.");
   chk_pu_write: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL7
      (wrEn && addr == `DBG_OFS_A_PULLUP) |=> stReg.aPullupReg == $past(pwdata[7:0]))
      else $error("Pull-up enable write lost.");
   chk_pu_read: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL7
      (rdEn && addr == `DBG_OFS_A_PULLUP) |=> prdata == {24'h000000, $past(stReg.aPullupReg)})
      else $error("Pull-up enable read wrong.");
   chk_reset_clear_b: assert property (@(posedge ref_clk) // RL14
      !rst_b |=> stReg.bDataReg == 8'h00 && stReg.bDirReg == 8'h00 && portBPinOe == 8'h00
      && portAPullupOn == 8'h00)
      else $error("Reset did not clear port B.");
   chk_sleep_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL16
      (stReg.modeReg == dbg_pkg::DBG_SLEEP && stNext.modeReg == dbg_pkg::DBG_SLEEP)
      |=> $stable(portAPinOut))
      else $error("Port A output changed in sleep.");
   chk_reset_clear: assert property (@(posedge ref_clk) // RL8
      !rst_b |=> stReg.aDataReg == 8'h00 && stReg.aDirReg == 8'h00 && portAPinOe == 8'h00)
      else $error("Reset did not clear port A.");
endmodule

// >>> logic/dbg_pkg.sv
// Types of the dual byte port block.
package dbg_pkg;
   typedef enum logic [1:0] {
      DBG_ACTIVE,
      DBG_SLEEP,
      DBG_STANDBY
   } dbg_mode_t;
   typedef struct packed {
      logic [7:0] aPullupReg;
      logic [7:0] aDataReg;
      logic [7:0] bDataReg;
      logic [7:0] aDirReg;
      logic [7:0] bDirReg;
      logic [7:0] aOutReg;
      logic [7:0] aOeReg;
      logic [7:0] aPuReg;
      logic [7:0] bOutReg;
      logic [7:0] bOeReg;
      logic [31:0] rdataReg;
      dbg_mode_t modeReg;
   } dbg_state_t;
endpackage

// >>> testbench/dbg_pin_board.sv
// Board model that sets the level seen on each port pin.
`timescale 1ns/1ps
module dbg_pin_board (
   input wire logic ref_clk,
   input wire logic [7:0] pinOut,
   input wire logic [7:0] pinOe,
   input wire logic [7:0] pullOn,
   input wire logic [7:0] extVal,
   input wire logic [7:0] extEn,
   output logic [7:0] pinLevel
);
   logic [7:0] lastReg = 8'h00;
   // A floating pin with no pull-up toggles so that it never looks settled.
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         if (pinOe[n]) pinLevel[n] = pinOut[n];
         else if (extEn[n]) pinLevel[n] = extVal[n];
         else if (pullOn[n]) pinLevel[n] = 1'b1;
         else pinLevel[n] = ~lastReg[n];
      end
   end
   always_ff @(posedge ref_clk) begin
      lastReg <= pinLevel;
   end
endmodule

// >>> testbench/tb_dbg_gpio_ports.sv
// Self-checking bench for the dual byte port block.
`timescale 1ns/1ps
`include "dbg_cfg.svh"
module tb_dbg_gpio_ports;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready;
   logic [7:0] aOut, aOe, aPu, aLvl, bOut, bOe, bLvl;
   logic [7:0] aExt = 8'h5a, aExtEn = 8'hff, bExt = 8'ha5;
   int numErrors = 0;
   int samplesChecked = 0;
   int cycles = 0;
   dbg_gpio_ports i_dbg_gpio_ports (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
      .prdata(prdata), .pready(pready), .pslverr(), .portAPinIn(aLvl), .portAPinOut(aOut),
      .portAPinOe(aOe), .portAPullupOn(aPu), .portBPinIn(bLvl), .portBPinOut(bOut),
      .portBPinOe(bOe));
   dbg_pin_board i_dbg_pin_board (.ref_clk(ref_clk), .pinOut(aOut), .pinOe(aOe),
      .pullOn(aPu), .extVal(aExt), .extEn(aExtEn), .pinLevel(aLvl));
   dbg_pin_board i_dbg_pin_board_b (.ref_clk(ref_clk), .pinOut(bOut), .pinOe(bOe),
      .pullOn(8'h00), .extVal(bExt), .extEn(8'hff), .pinLevel(bLvl));
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {14'h0, a, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", s, exp, got);
         numErrors++;
      end
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 8'h00);
      chk("read data", rd, exp);
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d.", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         numErrors++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (2) @(negedge ref_clk);
      chk("a oe", aOe, 8'h00);
      chk("a pullup", aPu, 8'h00);
      chk("b oe", bOe, 8'h00);
      rdchk(`DBG_OFS_A_DATA, 32'h5a);
      rdchk(`DBG_OFS_B_DATA, 32'ha5);
      rdchk(`DBG_OFS_A_PULLUP, 32'h00);
      rdchk(`DBG_OFS_A_DIR, 32'hff);
      rdchk(`DBG_OFS_B_DIR, 32'hff);
      rdchk(16'h1234, 32'h0);
      xfer(1'b1, `DBG_OFS_A_DIR, 8'hff);
      xfer(1'b1, `DBG_OFS_B_DIR, 8'hff);
      rdchk(`DBG_OFS_A_DATA, 32'h00);
      rdchk(`DBG_OFS_B_DATA, 32'h00);
      $display("Reset test done.");
      xfer(1'b1, `DBG_OFS_A_DATA, 8'hc3);
      xfer(1'b1, `DBG_OFS_B_DATA, 8'h3c);
      xfer(1'b1, `DBG_OFS_A_DIR, 8'hf0);
      xfer(1'b1, `DBG_OFS_B_DIR, 8'h0f);
      rdchk(`DBG_OFS_A_DATA, 32'hca);
      rdchk(`DBG_OFS_B_DATA, 32'hac);
      repeat (2) @(negedge ref_clk);
      chk("a oe", aOe, 8'hf0);
      chk("a out", aOut & 8'hf0, 8'hc0);
      chk("b oe", bOe, 8'h0f);
      chk("b out", bOut & 8'h0f, 8'h0c);
      $display("Direction test done.");
      aExtEn <= 8'h00;
      xfer(1'b1, `DBG_OFS_A_PULLUP, 8'hff);
      repeat (2) @(negedge ref_clk);
      chk("a pullup", aPu, 8'h0f);
      rdchk(`DBG_OFS_A_PULLUP, 32'hff);
      rdchk(`DBG_OFS_A_DATA, 32'hcf);
      $display("Pull-up test done.");
      xfer(1'b1, `DBG_OFS_MODE, 8'h01);
      xfer(1'b1, `DBG_OFS_A_DATA, 8'h00);
      repeat (2) @(negedge ref_clk);
      chk("a out", aOut & 8'hf0, 8'hc0);
      xfer(1'b1, `DBG_OFS_MODE, 8'h02);
      repeat (2) @(negedge ref_clk);
      chk("a oe", aOe, 8'h00);
      chk("a pullup", aPu, 8'h0f);
      chk("b oe", bOe, 8'h00);
      rdchk(`DBG_OFS_MODE, 32'h2);
      xfer(1'b1, `DBG_OFS_MODE, 8'h00);
      repeat (2) @(negedge ref_clk);
      chk("a oe", aOe, 8'hf0);
      chk("a out", aOut, 8'h00);
      xfer(1'b1, `DBG_OFS_MODE, 8'h03);
      xfer(1'b1, `DBG_OFS_B_DATA, 8'h05);
      repeat (2) @(negedge ref_clk);
      chk("b out", bOut & 8'h0f, 8'h05);
      xfer(1'b1, `DBG_OFS_MODE, 8'h00);
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (2) @(negedge ref_clk);
      chk("a oe", aOe, 8'h00);
      chk("a pullup", aPu, 8'h00);
      $display("Mode test done.");
      tally_and_finish();
   end
endmodule
